/* File: dv/mcc_conv_ctrl_bench.sv */
// Self-checking bench of the conversion control block with a reference model.
`timescale 1ns/10ps
`default_nettype none
module mcc_conv_ctrl_bench;
	// Short conversion counts; three cycles cover the two-flop input path.
	localparam int unsigned CT_SIM [8] = '{3, 4, 5, 6, 7, 8, 9, 10};
	localparam int LIMIT = 30000;
	localparam int AVG_N [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
	logic core_clk_in, arst_n_in, active, bus, smp, pdn;
	mcc_pkg::mcc_reg_req_t req;
	logic [12:0] adc;
	logic [15:0] rdata, q, cfg;
	logic [1:0]  ch;
	logic [10:0] avgc;
	logic [31:0] seed;
	logic [12:0] lv [6];       // Model copy of the input levels.
	logic [15:0] exp_res [4];  // Model of the four result registers.
	int err_total = 0, comparisons = 0, cycles = 0, pulses = 0, base, n;
	mcc_conv_ctrl #(.CT_CYC(CT_SIM)) mcc_conv_ctrl_inst (.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in), .reg_req_in(req), .adc_data_in(adc), .reg_rdata_out(rdata),
		.conv_active_out(active), .conv_ch_out(ch), .conv_bus_out(bus), .conv_sample_out(smp),
		.powered_down_out(pdn), .avg_count_out(avgc));
	mcc_host_model mcc_host_model_inst (.core_clk_in(core_clk_in), .conv_ch_in(ch),
		.conv_bus_in(bus), .reg_rdata_in(rdata), .reg_req_out(req), .adc_data_out(adc));
	////////////////////////////////////////
	initial
	begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	// Count samples and cycles; the ceiling cuts a hang short.
	always @(posedge core_clk_in)
	begin
		cycles++;
		if (smp === 1'b1) pulses++;
		if (cycles == LIMIT)
		begin
			err_total++;
			summarize();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic chk(input logic [15:0] seen, input logic [15:0] want, input string what);
		comparisons++;
		if (seen !== want)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask : chk
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	////////////////////////////////////////
	initial
	begin
		arst_n_in = 1'b0;
		seed = 32'd26;
		repeat (10) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		// Results and configuration straight after power-on; 05h is unmapped.
		for (int a = 1; a <= 5; a++)
		begin
			mcc_host_model_inst.reg_read(a[7:0], q);
			chk(q, 16'h0000, "result at reset");
		end
		for (int k = 0; k < 4; k++) exp_res[k] = 16'h0000;
		mcc_host_model_inst.reg_read(8'h00, q);
		chk(q, 16'h7127, "config at reset");
		chk({5'h00, avgc}, 16'h0001, "count at reset");
		// Every averaging code, written in power-down so nothing runs.
		for (int k = 0; k < 8; k++)
		begin
			mcc_host_model_inst.reg_write(8'h00, {4'h7, k[2:0], 9'h000});
			chk({5'h00, avgc}, AVG_N[k][15:0], "count decode");
			chk({15'h0000, pdn}, 16'h0001, "power-down flag");
		end
		// Every mode with random enables, times and levels.
		for (int i = 0; i < 12; i++)
		begin
			mcc_host_model_inst.reg_write(8'h00, 16'h0000);
			for (int j = 0; j < 6; j++)
			begin
				seed = xs(seed);
				lv[j] = seed[12:0];
				mcc_host_model_inst.level_tbl[j] <= seed[12:0];
			end
			seed = xs(seed);
			cfg = {1'b0, seed[15:13], 2'b00, seed[16], seed[22:17], i[2:0]};
			n = AVG_N[cfg[11:9]] * (int'(cfg[14]) + int'(cfg[13]) + int'(cfg[12]))
				* (int'(cfg[0]) + int'(cfg[1]));
			for (int c = 0; c < 2; c++)
			begin
				if (cfg[14 - c] && cfg[0]) exp_res[2 * c] = {lv[2 * c], 3'b000};
				if (cfg[14 - c] && cfg[1]) exp_res[2 * c + 1] = {lv[2 * c + 1], 3'b000};
			end
			base = pulses;
			mcc_host_model_inst.reg_write(8'h00, cfg);
			while (pulses - base < n) @(posedge core_clk_in);
			repeat (4) @(posedge core_clk_in);
			mcc_host_model_inst.reg_read(8'h00, q);
			chk(q, cfg, "config readback");
			// Triggered or idle setups must then stay quiet.
			if (!cfg[2] || n == 0)
			begin
				repeat (40) @(posedge core_clk_in);
				chk(16'(pulses - base), 16'(n), "sample count");
			end
			for (int a = 0; a < 4; a++)
			begin
				mcc_host_model_inst.reg_read(8'(a + 1), q);
				chk(q, exp_res[a], "result");
			end
		end
		// A write to a result register is ignored.
		mcc_host_model_inst.reg_write(8'h02, 16'h1234);
		mcc_host_model_inst.reg_read(8'h02, q);
		chk(q, exp_res[1], "read-only result");
		// The reset bit restores power-on values and clears itself.
		mcc_host_model_inst.reg_write(8'h00, 16'h8000);
		mcc_host_model_inst.reg_read(8'h01, q);
		chk(q, 16'h0000, "result after soft reset");
		mcc_host_model_inst.reg_read(8'h00, q);
		chk(q, 16'h7127, "config after soft reset");
		summarize();
	end
endmodule : mcc_conv_ctrl_bench
`default_nettype wire

/* File: dv/mcc_conv_ctrl_chk.sv */
// Concurrent checks of the conversion control block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module mcc_conv_ctrl_chk #(
	parameter int unsigned CT_CYC [8] = mcc_pkg::CT_CYC_DEF
) (
	input wire logic                         core_clk_in,
	input wire logic                         arst_n_in,
	input wire mcc_pkg::mcc_reg_req_t        reg_req_in,
	input wire logic [mcc_pkg::SAMPLE_W-1:0] adc_data_in,
	input wire logic [15:0]                  reg_rdata_out,
	input wire logic                         conv_active_out,
	input wire logic [1:0]                   conv_ch_out,
	input wire logic                         conv_bus_out,
	input wire logic                         conv_sample_out,
	input wire logic                         powered_down_out,
	input wire logic [10:0]                  avg_count_out
);
	////////////////////////////////////////
	logic [14:0] shadow_ff; // Host view of the stored configuration.
	logic        halt_ff;   // A configuration write still holds the sequencer.
	logic [10:0] avg_want;  // Count that the stored code selects.
	logic        chan_ok;   // Slot on the converter is one the setup allows.
	logic [19:0] cyc_ff;    // Cycle number within the running conversion.
	always_ff @(posedge core_clk_in or negedge arst_n_in)
		if (!arst_n_in) cyc_ff <= '0;
		else cyc_ff <= (conv_sample_out || !conv_active_out) ? 20'h00001 : cyc_ff + 20'h00001;
	// Mirror configuration writes; the reset bit restores the power-on value.
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			shadow_ff <= mcc_pkg::CFG_RST_VAL;
			halt_ff   <= 1'b0;
		end
		else if (reg_req_in.wr && reg_req_in.addr == mcc_pkg::ADDR_CFG)
		begin
			shadow_ff <= reg_req_in.wdata[15] ? mcc_pkg::CFG_RST_VAL : reg_req_in.wdata[14:0];
			halt_ff   <= !reg_req_in.wdata[15];
		end
		else if (!reg_req_in.busy)
			halt_ff <= 1'b0;
	end
	// Codes 0 to 3 step by four, the upper codes by two; kept apart from the package table.
	assign avg_want = (shadow_ff[11:9] < 3'h4) ? (11'h1 << {shadow_ff[11:9], 1'b0})
		: (11'h1 << ({1'b0, shadow_ff[11:9]} + 4'h3));
	assign chan_ok = shadow_ff[4'd14 - {2'b00, conv_ch_out}]
		&& (conv_bus_out ? shadow_ff[1] : shadow_ff[0]);
	////////////////////////////////////////
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	// Two quiet cycles let any write settle before the decoded outputs are judged.
	a_avg_decode: assert property ((!reg_req_in.wr)[*2] |-> avg_count_out == avg_want)
		else $error("Averaging count differs from the stored code.");
	a_pwrdn_flag: assert property ((!reg_req_in.wr)[*2] |-> powered_down_out == (shadow_ff[1:0] == 2'b00))
		else $error("Power-down flag differs from the mode code.");
	a_pwrdn_quiet: assert property (powered_down_out |-> !conv_sample_out)
		else $error("Sample taken while powered down.");
	a_slot_allowed: assert property (conv_active_out |-> chan_ok)
		else $error("Conversion on a disabled channel or signal.");
	a_halt_busy: assert property (halt_ff |-> !conv_active_out)
		else $error("Conversion runs during a configuration write.");
	a_cfg_readback: assert property (reg_req_in.rd && !reg_req_in.wr && reg_req_in.addr == 8'h00
		|=> reg_rdata_out == {1'b0, $past(shadow_ff)})
		else $error("Configuration read back wrong.");
	a_unmapped_zero: assert property (reg_req_in.rd && reg_req_in.addr > mcc_pkg::ADDR_RES_LAST
		|=> reg_rdata_out == 16'h0000)
		else $error("Unmapped read not zero.");
	a_result_pad: assert property (reg_req_in.rd && reg_req_in.addr >= 8'h01 && reg_req_in.addr <= 8'h04
		|=> reg_rdata_out[2:0] == 3'b000)
		else $error("Result low bits not zero.");
	a_slot_steady: assert property (conv_active_out && $past(conv_active_out)
		|-> $stable(conv_ch_out) && $stable(conv_bus_out))
		else $error("Slot changed in mid conversion.");
	a_soft_reset: assert property (reg_req_in.wr && reg_req_in.addr == 8'h00 && reg_req_in.wdata[15]
		|=> !conv_active_out && reg_rdata_out == 16'h0000)
		else $error("Reset bit did not restore power-on state.");
	a_conv_time: assert property (conv_sample_out && conv_active_out
		|-> 32'(cyc_ff) == CT_CYC[conv_bus_out ? shadow_ff[8:6] : shadow_ff[5:3]])
		else $error("Conversion length differs from the time code.");
	c_soft_reset: cover property (reg_req_in.wr && reg_req_in.wdata[15]);
	c_bus_sample: cover property (conv_sample_out && conv_bus_out);
	c_unmapped: cover property (reg_req_in.rd && reg_req_in.addr == 8'h05);
endmodule : mcc_conv_ctrl_chk
bind mcc_conv_ctrl mcc_conv_ctrl_chk #(.CT_CYC(CT_CYC)) chk_inst (.core_clk_in(core_clk_in),
	.arst_n_in(arst_n_in), .reg_req_in(reg_req_in), .adc_data_in(adc_data_in),
	.reg_rdata_out(reg_rdata_out), .conv_active_out(conv_active_out), .conv_ch_out(conv_ch_out),
	.conv_bus_out(conv_bus_out), .conv_sample_out(conv_sample_out),
	.powered_down_out(powered_down_out), .avg_count_out(avg_count_out));
`default_nettype wire

/* File: dv/mcc_host_model.sv */
// Host controller and analog front end that stand around the conversion control block.
`timescale 1ns/10ps
`default_nettype none
module mcc_host_model (
	input  wire logic            core_clk_in,
	input  wire logic [1:0]      conv_ch_in,
	input  wire logic            conv_bus_in,
	input  wire logic [15:0]     reg_rdata_in,
	output var mcc_pkg::mcc_reg_req_t reg_req_out,
	output logic [12:0]          adc_data_out
);
	logic [12:0] level_tbl [6]; // Input level per slot; the bench loads it.
	initial
	begin
		reg_req_out = '0;
		for (int j = 0; j < 6; j++) level_tbl[j] = 13'h0000;
	end
	// The converter sees the level of whichever slot is selected.
	always_comb adc_data_out = level_tbl[int'(conv_ch_in) * 2 + int'(conv_bus_in)];
	// Busy stays up past the strobe, as a serial transaction would.
	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		reg_req_out.wr    <= 1'b1;
		reg_req_out.busy  <= 1'b1;
		reg_req_out.addr  <= a;
		reg_req_out.wdata <= d;
		@(posedge core_clk_in);
		reg_req_out.wr <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		reg_req_out.busy  <= 1'b0;
		reg_req_out.wdata <= ~d; // Released data lines show no stale value.
	endtask : reg_write
	// Read data is taken just after the edge that samples the strobe.
	task automatic reg_read(input logic [7:0] a, output logic [15:0] q);
		@(posedge core_clk_in);
		reg_req_out.rd   <= 1'b1;
		reg_req_out.addr <= a;
		@(posedge core_clk_in);
		reg_req_out.rd <= 1'b0;
		#1 q = reg_rdata_in;
	endtask : reg_read
endmodule : mcc_host_model
`default_nettype wire

/* File: rtl/mcc_avg_accum.sv */
// Signed accumulator that averages a power-of-two number of samples.
`timescale 1ns/10ps
`default_nettype none
module mcc_avg_accum #(
	parameter int SW = 13,
	parameter int AW = 23
) (
	input  wire logic              core_clk_in,  // Core clock.
	input  wire logic              arst_n_in,    // Asynchronous reset, active low.
	input  wire logic              clr_in,       // Empty the sum; wins over add.
	input  wire logic              add_in,       // Add the sample this cycle.
	input  wire logic signed [SW-1:0] sample_in, // Signed sample.
	input  wire logic [3:0]        shift_in,     // log2 of the sample count.
	output logic [SW-1:0]          avg_out       // Sum divided by the count.
);

	////////////////////////////////////////////////////////////////////////////////
	// State.
	////////////////////////////////////////////////////////////////////////////////

	logic signed [AW-1:0] acc_ff;    // Running signed sum.
	logic signed [AW-1:0] nxt_acc;   // Next sum.
	logic signed [AW-1:0] shifted;   // Arithmetic shift of the sum.

	// Sign-extends each sample so negative readings average correctly.
	always_comb
	begin
		nxt_acc = acc_ff;
		if (clr_in)
			nxt_acc = '0;
		else if (add_in)
			nxt_acc = acc_ff + AW'(sample_in);
	end

	// Registers the sum.
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			acc_ff <= '0;
		else
			acc_ff <= nxt_acc;
	end

	// Truncating divide; the average of in-range samples always fits the sample width.
	assign shifted = acc_ff >>> shift_in;
	assign avg_out = shifted[SW-1:0];

endmodule : mcc_avg_accum
`default_nettype wire

/* File: rtl/mcc_conv_ctrl.sv */
// Configuration register, conversion sequencer and result registers of the monitor.
//
// How it works
// - averaging code selects 1 to 1024 samples
// - bus time code selects conversion time
// - shunt time code uses same time table
// - mode 000 or 100 means power-down
// - low mode bits pick signals, top continuous
// - reset mode is continuous shunt and bus
// - only enabled channels are measured
// - reading configuration changes nothing
// - config write halts, then restarts conversion
// - result registers one to four, zero after reset
// - shunt result sign, twelve bits, zero pad
// - negative results two's complement, sign extended
// - bus results same format at 02h, 04h
// - bits 14 to 12 enable channels 1 to 3
// - reset bit restores everything, reads zero
`timescale 1ns/10ps
`default_nettype none
module mcc_conv_ctrl #(
	// Conversion time counts per code; shorten these in simulation.
	parameter int unsigned CT_CYC [8] = mcc_pkg::CT_CYC_DEF
) (
	input  wire logic                          core_clk_in,     // Core clock, 125 MHz.
	input  wire logic                          arst_n_in,       // Power-on reset, low.
	input  wire mcc_pkg::mcc_reg_req_t         reg_req_in,      // Register access.
	input  wire logic [mcc_pkg::SAMPLE_W-1:0]  adc_data_in,     // Converter output.
	output logic [15:0]                        reg_rdata_out,   // Read data.
	output logic                               conv_active_out, // Converter running.
	output logic [1:0]                         conv_ch_out,     // Channel 0..2 in use.
	output logic                               conv_bus_out,    // 1 bus, 0 shunt.
	output logic                               conv_sample_out, // Take sample now.
	output logic                               powered_down_out,// Mode is power-down.
	output logic [mcc_pkg::AVG_CNT_W-1:0]      avg_count_out    // Decoded count.
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	////////////////////////////////////////////////////////////////////////////////

	mcc_pkg::mcc_regs_t                st_ff;       // All registered state.
	mcc_pkg::mcc_regs_t                nxt_st;      // Its next value.
	logic                              tmr_start;   // Start a conversion.
	logic                              tmr_abort;   // Kill a conversion.
	logic                              tmr_done;    // Conversion finished.
	logic [mcc_pkg::TMR_W-1:0]         tmr_load;    // Cycles for the one being started.
	logic                              acc_clr;     // Empty the averager.
	logic                              acc_add;     // Feed the averager.
	logic [mcc_pkg::SAMPLE_W-1:0]      acc_avg;     // Averaged value.
	logic [3:0]                        acc_shift;   // Divide as a shift.
	logic [2:0]                        avg_sel;     // Averaging code.
	logic [2:0]                        mode_sel;    // Operating mode code.
	logic                              go;          // Begin a slot this cycle.
	logic [2:0]                        go_slot;     // Which slot to begin.
	logic [3:0]                        found;       // Search result, found flag on top.
	logic                              cfg_wr;      // Write to configuration.

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.
	////////////////////////////////////////////////////////////////////////////////

	// A slot is channel (upper two bits) and signal (low bit, 1 is bus).
	// Returns the first active slot at or after from, with a found flag on top.
	function automatic logic [3:0] find_slot(input logic [2:0] from, input logic [14:0] cfg);
		logic [3:0] r;
		logic [1:0] ch;
		logic       sig_on;
		logic       ch_on;
		r = 4'h0;
		for (int i = 0; i < mcc_pkg::NUM_SLOTS; i++)
		begin
			ch = 2'(i >> 1);
			// Channel 1 sits on the highest enable bit.
			ch_on  = cfg[mcc_pkg::CFG_CHANNEL_ENABLE_BITS_POS + 2 - int'(ch)];
			// Mode bit 0 picks shunt, bit 1 picks bus; neither means nothing to do.
			sig_on = (i % 2 == 1) ? cfg[mcc_pkg::CFG_MODE_POS + 1]
			                      : cfg[mcc_pkg::CFG_MODE_POS];
			if (!r[3] && (i >= int'(from)) && ch_on && sig_on)
				r = {1'b1, 3'(i)};
		end
		return r;
	endfunction : find_slot

	assign avg_sel  = st_ff.cfg[mcc_pkg::CFG_AVG_POS +: 3];
	assign mode_sel = st_ff.cfg[mcc_pkg::CFG_MODE_POS +: 3];
	assign cfg_wr   = reg_req_in.wr && (reg_req_in.addr == mcc_pkg::ADDR_CFG);

	// The decoded count and its shift come from the same code.
	assign acc_shift = 4'(mcc_pkg::AVG_SHIFT[avg_sel]);

	////////////////////////////////////////////////////////////////////////////////
	// Sub-blocks.
	////////////////////////////////////////////////////////////////////////////////

	// Times each conversion from the selected time code.
	mcc_conv_timer #(
		.W          (mcc_pkg::TMR_W)
	) u_timer (
		.core_clk_in(core_clk_in),
		.arst_n_in  (arst_n_in),
		.start_in   (tmr_start),
		.abort_in   (tmr_abort),
		.load_in    (tmr_load),
		.busy_out   (),
		.done_out   (tmr_done)
	);

	// Averages the samples of one slot.
	mcc_avg_accum #(
		.SW         (mcc_pkg::SAMPLE_W),
		.AW         (mcc_pkg::ACC_W)
	) u_avg (
		.core_clk_in(core_clk_in),
		.arst_n_in  (arst_n_in),
		.clr_in     (acc_clr),
		.add_in     (acc_add),
		.sample_in  (st_ff.adc_sync),
		.shift_in   (acc_shift),
		.avg_out    (acc_avg)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer and register file.
	////////////////////////////////////////////////////////////////////////////////

	// Walks the active slots, averaging each, and serves register access.
	always_comb
	begin
		nxt_st    = st_ff;
		tmr_start = 1'b0;
		tmr_abort = 1'b0;
		acc_clr   = 1'b0;
		acc_add   = 1'b0;
		go        = 1'b0;
		go_slot   = 3'h0;
		found     = 4'h0;

		// The converter output is asynchronous to this clock: two stages first.
		nxt_st.adc_meta = adc_data_in;
		nxt_st.adc_sync = st_ff.adc_meta;

		// Reads only load the read-data register, never settings or conversions.
		if (reg_req_in.rd)
		begin
			if (reg_req_in.addr == mcc_pkg::ADDR_CFG)
				nxt_st.rdata = {1'b0, st_ff.cfg};
			else if ((reg_req_in.addr >= mcc_pkg::ADDR_RES_FIRST) &&
			         (reg_req_in.addr <= mcc_pkg::ADDR_RES_LAST))
				nxt_st.rdata = st_ff.res[2'(reg_req_in.addr - mcc_pkg::ADDR_RES_FIRST)];
			else
				nxt_st.rdata = 16'h0000;
		end

		case (st_ff.fsm)
			mcc_pkg::FSM_IDLE:
			begin
				// Power-down codes enable no signal, so nothing is found.
				found = find_slot(3'h0, st_ff.cfg);
				go      = found[3];
				go_slot = found[2:0];
			end
			mcc_pkg::FSM_CONV:
			begin
				if (tmr_done)
				begin
					acc_add = 1'b1;
					if (st_ff.n_left == mcc_pkg::AVG_CNT_W'(1))
					begin
						nxt_st.fsm = mcc_pkg::FSM_STORE;
					end
					else
					begin
						// Another sample of the same slot.
						nxt_st.n_left = st_ff.n_left - mcc_pkg::AVG_CNT_W'(1);
						tmr_start     = 1'b1;
					end
				end
			end
			mcc_pkg::FSM_STORE:
			begin
				// Signed average on bits 15..3, zeros below; channel 3 is not kept.
				if (int'(st_ff.slot) < mcc_pkg::NUM_RES)
					nxt_st.res[st_ff.slot[1:0]] =
						{acc_avg, {mcc_pkg::PAD_W{1'b0}}};
				acc_clr = 1'b1;
				found = find_slot(st_ff.slot + 3'h1, st_ff.cfg);
				if (found[3])
				begin
					go      = 1'b1;
					go_slot = found[2:0];
				end
				else if (mode_sel[2])
				begin
					nxt_st.fsm = mcc_pkg::FSM_IDLE;
				end
				else
				begin
					nxt_st.fsm = mcc_pkg::FSM_HOLD;
				end
			end
			mcc_pkg::FSM_HALT:
			begin
				// Nothing converts until the bus transaction has closed.
				if (!reg_req_in.busy)
					nxt_st.fsm = mcc_pkg::FSM_IDLE;
			end
			mcc_pkg::FSM_HOLD:
			begin
				// A triggered pass is over; only a configuration write leaves.
				nxt_st.fsm = mcc_pkg::FSM_HOLD;
			end
			default:
			begin
				nxt_st.fsm = mcc_pkg::FSM_IDLE;
			end
		endcase

		// Starts the first sample of a slot with a fresh count.
		if (go)
		begin
			nxt_st.fsm    = mcc_pkg::FSM_CONV;
			nxt_st.slot   = go_slot;
			nxt_st.n_left = mcc_pkg::AVG_CNT_W'(mcc_pkg::AVG_COUNT[avg_sel]);
			tmr_start     = 1'b1;
		end

		// A configuration write throws away the running pass, whatever state.
		if (cfg_wr)
		begin
			tmr_abort  = 1'b1;
			acc_clr    = 1'b1;
			tmr_start  = 1'b0;
			nxt_st.cfg = reg_req_in.wdata[14:0];
			nxt_st.fsm = mcc_pkg::FSM_HALT;
			if (reg_req_in.wdata[mcc_pkg::CFG_RST_POS])
			begin
				// Same as power-on; the reset bit itself is never stored.
				nxt_st = mcc_pkg::REGS_RST;
			end
		end
	end

	// Time code of the slot being started; bus and shunt share one table.
	always_comb
	begin
		if (nxt_st.slot[0])
			tmr_load = mcc_pkg::TMR_W'(CT_CYC[st_ff.cfg[mcc_pkg::CFG_BCT_POS +: 3]]);
		else
			tmr_load = mcc_pkg::TMR_W'(CT_CYC[st_ff.cfg[mcc_pkg::CFG_SCT_POS +: 3]]);
	end

	// Registers the whole state; reset gives continuous mode and zero results.
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			st_ff <= mcc_pkg::REGS_RST;
		else
			st_ff <= nxt_st;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	////////////////////////////////////////////////////////////////////////////////

	assign reg_rdata_out    = st_ff.rdata;
	assign conv_active_out  = (st_ff.fsm == mcc_pkg::FSM_CONV);
	assign conv_ch_out      = st_ff.slot[2:1];
	assign conv_bus_out     = st_ff.slot[0];
	assign conv_sample_out  = tmr_done;
	assign powered_down_out = (mode_sel[1:0] == 2'b00);
	assign avg_count_out    = mcc_pkg::AVG_CNT_W'(mcc_pkg::AVG_COUNT[avg_sel]);

endmodule : mcc_conv_ctrl
`default_nettype wire

/* File: rtl/mcc_conv_timer.sv */
// Down-counter that times one conversion and pulses when it ends.
`timescale 1ns/10ps
`default_nettype none
module mcc_conv_timer #(
	parameter int W = 20
) (
	input  wire logic         core_clk_in,  // Core clock.
	input  wire logic         arst_n_in,    // Asynchronous reset, active low.
	input  wire logic         start_in,     // Load the count and run.
	input  wire logic         abort_in,     // Stop at once; wins over start.
	input  wire logic [W-1:0] load_in,      // Cycles to run, at least one.
	output logic              busy_out,     // High while counting.
	output logic              done_out      // One-cycle pulse in the last cycle.
);

	////////////////////////////////////////////////////////////////////////////////
	// State: run flag on top of the remaining count.
	////////////////////////////////////////////////////////////////////////////////

	logic [W:0] st_ff;     // Registered run flag and count.
	logic [W:0] nxt_st;    // Next value.

	// Counts down; the pulse falls in the cycle where one cycle remains.
	always_comb
	begin
		nxt_st = st_ff;
		if (abort_in)
		begin
			nxt_st = '0;
		end
		else if (start_in)
		begin
			nxt_st = {1'b1, load_in};
		end
		else if (st_ff[W])
		begin
			// The last cycle drops the run flag together with the count.
			nxt_st = (st_ff[W-1:0] == W'(1)) ? '0 : {1'b1, st_ff[W-1:0] - W'(1)};
		end
	end

	// Registers the state.
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign busy_out = st_ff[W];
	assign done_out = st_ff[W] && (st_ff[W-1:0] == W'(1)) && !abort_in;

endmodule : mcc_conv_timer
`default_nettype wire

/* File: rtl/mcc_pkg.sv */
// Shared constants, state encodings and carrier structs of the conversion control block.
package mcc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clocking and conversion times.
	////////////////////////////////////////////////////////////////////////////////

	localparam int unsigned CLK_MHZ    = 125;                // Core clock rate in MHz.
	// Conversion times in microseconds, indexed by the three-bit time code.
	localparam int unsigned CT_US [8]  = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
	// Cycle counts derived from the times; the times are whole microseconds, so exact.
	localparam int unsigned CT_CYC_DEF [8] = '{
		CT_US[0] * CLK_MHZ, CT_US[1] * CLK_MHZ, CT_US[2] * CLK_MHZ, CT_US[3] * CLK_MHZ,
		CT_US[4] * CLK_MHZ, CT_US[5] * CLK_MHZ, CT_US[6] * CLK_MHZ, CT_US[7] * CLK_MHZ};
	localparam int          TMR_W      = 20;                 // Holds the longest count.

	////////////////////////////////////////////////////////////////////////////////
	// Averaging.
	////////////////////////////////////////////////////////////////////////////////

	localparam int unsigned AVG_COUNT [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
	localparam int unsigned AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10}; // log2 of count.
	localparam int          AVG_CNT_W  = 11;                 // Holds a count of 1024.
	localparam int          SAMPLE_W   = 13;                 // Signed sample width.
	localparam int          ACC_W      = 23;                 // Sample plus 10 growth bits.
	localparam int          PAD_W      = 3;                  // Zero bits below a result.

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets, field positions and reset values.
	////////////////////////////////////////////////////////////////////////////////

	localparam logic [7:0]  ADDR_CFG        = 8'h00;         // Configuration.
	localparam logic [7:0]  ADDR_RES_FIRST  = 8'h01;         // Channel 1 shunt result.
	localparam logic [7:0]  ADDR_RES_LAST   = 8'h04;         // Channel 2 bus result.
	localparam int          CFG_RST_POS     = 15;            // Self-clearing reset bit.
	localparam int          CFG_CHANNEL_ENABLE_BITS_POS    = 12;            // Channel enables, ch3 lowest.
	localparam int          CFG_AVG_POS     = 9;             // Averaging code.
	localparam int          CFG_BCT_POS     = 6;             // Bus time code.
	localparam int          CFG_SCT_POS     = 3;             // Shunt time code.
	localparam int          CFG_MODE_POS    = 0;             // Operating mode.
	localparam logic [14:0] CFG_RST_VAL     = 15'h7127;      // Stored bits after reset.
	localparam logic [15:0] RES_RST_VAL     = 16'h0000;      // Result registers after reset.
	localparam int          NUM_SLOTS       = 6;             // Three channels, two signals.
	localparam int          NUM_RES         = 4;             // Result registers kept.

	////////////////////////////////////////////////////////////////////////////////
	// Types.
	////////////////////////////////////////////////////////////////////////////////

	// Sequencer states.
	typedef enum logic [2:0] {
		FSM_IDLE  = 3'b000,
		FSM_CONV  = 3'b001,
		FSM_STORE = 3'b010,
		FSM_HALT  = 3'b011,
		FSM_HOLD  = 3'b100
	} mcc_fsm_t;

	// Register access request from the serial bus engine.
	typedef struct packed {
		logic        wr;      // One-cycle write strobe.
		logic        rd;      // One-cycle read strobe.
		logic [7:0]  addr;    // Register pointer.
		logic [15:0] wdata;   // Write data.
		logic        busy;    // Level: bus transaction still open.
	} mcc_reg_req_t;

	// Whole state of the top module.
	typedef struct packed {
		mcc_fsm_t                   fsm;
		logic [14:0]                cfg;
		logic [NUM_RES-1:0][15:0]   res;
		logic [2:0]                 slot;
		logic [AVG_CNT_W-1:0]       n_left;
		logic [SAMPLE_W-1:0]        adc_meta;
		logic [SAMPLE_W-1:0]        adc_sync;
		logic [15:0]                rdata;
	} mcc_regs_t;

	localparam mcc_regs_t REGS_RST = '{
		fsm: FSM_IDLE, cfg: CFG_RST_VAL, res: {NUM_RES{RES_RST_VAL}}, slot: 3'h0,
		n_left: 11'h001, adc_meta: 13'h0000, adc_sync: 13'h0000, rdata: 16'h0000};

endpackage : mcc_pkg
